// ### common/fault_regs_consts.vh
// Command codes, field positions and reset values of the fault status and enable registers
`ifndef FAULT_REGS_CONSTS_VH
`define FAULT_REGS_CONSTS_VH
`define CMD_LIVE_STATUS 8'h00
`define CMD_LATCH_ENABLE 8'h08
`define CMD_LATCHED_FLAGS 8'h11
`define LATCH_ENABLE_RESET 16'h0000
`define NUM_FAULT_BITS 14
`define BIT_CH0A_OV 0
`define BIT_CH0A_UV 1
`define BIT_CH1A_OV 5
`define BIT_CH1A_UV 6
`define BIT_RESERVO_CH0A 14
`define BIT_RESERVO_CH1A 15
`endif

// ### core/reservo_trigger.v
// One-shot re-servo request for one channel on a live voltage fault
`timescale 1ns/10ps
`default_nettype none
module reservo_trigger
(
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Conditions
  input wire reservo_on_event,
  input wire servo_enabled,
  input wire continuous_servo,
  input wire monitor_select,
  input wire voltage_fault,
  // Request
  output reg reservo_request
);
  reg fault_seen;
  wire armed;

  // Gated by servo enable, single-shot mode and monitoring
  assign armed = reservo_on_event & servo_enabled & ~continuous_servo & monitor_select;

  // Rising fault edge so a persistent fault asks for one servo, not a stream
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      fault_seen <= 1'b0;
      reservo_request <= 1'b0;
    end
    else
    begin
      fault_seen <= voltage_fault;
      reservo_request <= armed & voltage_fault & ~fault_seen;
    end
  end
endmodule
`default_nettype wire

// ### core/supply_fault_status_enable.v
// Live fault status, enable mask and latched flags with fault-driven re-servo requests
`include "fault_regs_consts.vh"
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] Channel faults map to live status bits 0 through 9 in fixed order.
// [R2] Status bit is one while fault is present; rails at 10-13; 15:14 zero.
// [R3] Live status follows present conditions without latching.
// [R4] Fourteen enable bits default zero; zero holds matching latched flag at zero.
// [R5] Enabled live fault sets its latched flag.
// [R6] Enable bit 14 requests one re-servo of chan0a on live OV or UV.
// [R7] Chan0a re-servo needs servo on, continuous mode off, monitoring on.
// [R8] Enable bit 15 does the same for chan1a under same conditions.
// [R9] Latched flags hold until the latched register is read, then clear.
// [R10] Writing zero to an enable bit clears its latched flag at once.
// [R11] Live status at command 0x00 read-only; enable mask at 0x08 read/write.
// [R12] Writes to live status change nothing.
module supply_fault_status_enable
(
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Live fault comparators, asynchronous to clk
  input wire chan0a_overvoltage_now,
  input wire chan0a_undervoltage_now,
  input wire chan0a_dac_limit_now,
  input wire chan0b_overvoltage_now,
  input wire chan0b_undervoltage_now,
  input wire chan1a_overvoltage_now,
  input wire chan1a_undervoltage_now,
  input wire chan1a_dac_limit_now,
  input wire chan1b_overvoltage_now,
  input wire chan1b_undervoltage_now,
  input wire supply_rail_over_now,
  input wire supply_rail_under_now,
  input wire twelve_volt_over_now,
  input wire twelve_volt_under_now,
  // Servo configuration from the servo and monitor registers
  input wire chan0a_servo_enabled,
  input wire chan0a_continuous_servo,
  input wire chan0a_monitor_select,
  input wire chan1a_servo_enabled,
  input wire chan1a_continuous_servo,
  input wire chan1a_monitor_select,
  // Word access from the command decoder
  input wire [7:0] cmd_code,
  input wire wr_strobe,
  input wire [15:0] wr_data,
  input wire rd_strobe,
  output reg [15:0] rd_data,
  output reg rd_valid,
  // Results
  output reg [13:0] latched_event_flags,
  output reg chan0a_reservo_request,
  output reg chan1a_reservo_request
);
  reg [13:0] sync1;
  reg [13:0] live;
  reg [15:0] latch_enable_mask;
  reg [13:0] next_flags;
  wire [13:0] raw_faults;
  wire [15:0] live_status_word;
  wire req0;
  wire req1;
  wire mask_wr;
  wire flags_rd;
  wire chan0a_vfault;
  wire chan1a_vfault;
  wire [13:0] fault_sets;
  reg [15:0] next_rd_data;

  // Command decode shared by the write and clear paths
  function cmd_is;
    input [7:0] code;
    input [7:0] target;
    begin
      cmd_is = (code == target);
    end
  endfunction

  // Either voltage fault of a channel can ask for a re-servo; current-DAC faults cannot
  function volt_fault;
    input ov;
    input uv;
    begin
      volt_fault = ov | uv;
    end
  endfunction

  // Pins from the analog side are asynchronous; live view lags pins by two cycles
  assign raw_faults = {
    twelve_volt_under_now,
    twelve_volt_over_now,
    supply_rail_under_now,
    supply_rail_over_now,
    chan1b_undervoltage_now,
    chan1b_overvoltage_now,
    chan1a_dac_limit_now,
    chan1a_undervoltage_now,
    chan1a_overvoltage_now,
    chan0b_undervoltage_now,
    chan0b_overvoltage_now,
    chan0a_dac_limit_now,
    chan0a_undervoltage_now,
    chan0a_overvoltage_now
  }; // R1

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1 <= 14'h0000;
      live <= 14'h0000;
    end
    else
    begin
      sync1 <= raw_faults;
      live <= sync1; // R3
    end
  end

  assign live_status_word = {2'b00, live}; // R2

  // Per-channel voltage fault and the enabled set terms
  assign chan0a_vfault = volt_fault(live[`BIT_CH0A_OV], live[`BIT_CH0A_UV]); // R6
  assign chan1a_vfault = volt_fault(live[`BIT_CH1A_OV], live[`BIT_CH1A_UV]); // R8
  assign fault_sets = live & latch_enable_mask[13:0]; // R5

  assign mask_wr = wr_strobe && cmd_is(cmd_code, `CMD_LATCH_ENABLE); // R11 R12
  assign flags_rd = rd_strobe && cmd_is(cmd_code, `CMD_LATCHED_FLAGS);

  always @(posedge clk)
  begin
    if (!rstn)
      latch_enable_mask <= `LATCH_ENABLE_RESET; // R4
    else if (mask_wr)
      latch_enable_mask <= wr_data; // R11
  end

  // Read clears first, then live faults set again: a set in the read cycle is kept
  always @*
  begin
    next_flags = latched_event_flags;
    if (flags_rd)
      next_flags = 14'h0000; // R9
    next_flags = next_flags | fault_sets; // R5
    next_flags = next_flags & latch_enable_mask[13:0]; // R4
    if (mask_wr)
      next_flags = next_flags & wr_data[13:0]; // R10
  end

  always @(posedge clk)
  begin
    if (!rstn)
      latched_event_flags <= 14'h0000;
    else
      latched_event_flags <= next_flags; // R9
  end

  // Unknown codes read as zero
  always @*
  begin
    next_rd_data = 16'h0000;
    case (cmd_code)
      `CMD_LIVE_STATUS: next_rd_data = live_status_word; // R11
      `CMD_LATCH_ENABLE: next_rd_data = latch_enable_mask;
      `CMD_LATCHED_FLAGS: next_rd_data = {2'b00, latched_event_flags};
      default: next_rd_data = 16'h0000;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_strobe;
      if (rd_strobe)
        rd_data <= next_rd_data; // R11
    end
  end

  reservo_trigger u_reservo0
  (
    .clk(clk),
    .rstn(rstn),
    .reservo_on_event(latch_enable_mask[`BIT_RESERVO_CH0A]),
    .servo_enabled(chan0a_servo_enabled),
    .continuous_servo(chan0a_continuous_servo),
    .monitor_select(chan0a_monitor_select),
    .voltage_fault(chan0a_vfault),
    .reservo_request(req0)
  ); // R6 R7

  reservo_trigger u_reservo1
  (
    .clk(clk),
    .rstn(rstn),
    .reservo_on_event(latch_enable_mask[`BIT_RESERVO_CH1A]),
    .servo_enabled(chan1a_servo_enabled),
    .continuous_servo(chan1a_continuous_servo),
    .monitor_select(chan1a_monitor_select),
    .voltage_fault(chan1a_vfault),
    .reservo_request(req1)
  ); // R8

  // Outputs straight from flops
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      chan0a_reservo_request <= 1'b0;
      chan1a_reservo_request <= 1'b0;
    end
    else
    begin
      chan0a_reservo_request <= req0;
      chan1a_reservo_request <= req1;
    end
  end
endmodule
`default_nettype wire

// ### sim/supply_fault_checker.sv
// Port checker for the fault status and enable block
`timescale 1ns/10ps
`default_nettype none
module supply_fault_checker
(
  // Clock, reset and word access
  input wire clk, input wire rstn, input wire [7:0] cmd_code, input wire wr_strobe, input wire [15:0] wr_data,
  input wire rd_strobe, input wire [15:0] rd_data, input wire rd_valid,
  // Results
  input wire [13:0] latched_event_flags, input wire chan0a_reservo_request, input wire chan1a_reservo_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rd_answer: assert property (rd_strobe |=> rd_valid) else $error("no answer");
  chk_rd_single: assert property (!rd_strobe |=> !rd_valid) else $error("stray answer");
  chk_top_zero: assert property (rd_valid && $past(cmd_code) != 8'h08 |-> rd_data[15:14] == 2'b00)
    else $error("top bits set");
  chk_flag_read: assert property (rd_valid && $past(cmd_code) == 8'h11 |-> rd_data[13:0] == $past(latched_event_flags))
    else $error("flag read");
  chk_mask_clear: assert property (wr_strobe && cmd_code == 8'h08 |=> (latched_event_flags & ~$past(wr_data[13:0])) == 14'h0000)
    else $error("mask clear");
  chk_flag_hold: assert property (!wr_strobe && !(rd_strobe && cmd_code == 8'h11) |=>
    (latched_event_flags & $past(latched_event_flags)) == $past(latched_event_flags)) else $error("flag lost");
  chk_req0_pulse: assert property (chan0a_reservo_request |=> !chan0a_reservo_request) else $error("req0 long");
  chk_req1_pulse: assert property (chan1a_reservo_request |=> !chan1a_reservo_request) else $error("req1 long");
endmodule
bind supply_fault_status_enable supply_fault_checker i_chk (.*);
`default_nettype wire

// ### sim/fault_host_model.sv
// Host model issuing word reads and writes to the fault registers
`timescale 1ns/10ps
`default_nettype none
module fault_host_model
(
  // Clock
  input wire clk,
  // Word access
  output logic [7:0] cmd_code, output logic wr_strobe, output logic [15:0] wr_data, output logic rd_strobe,
  input wire [15:0] rd_data, input wire rd_valid
);
  initial {cmd_code, wr_strobe, wr_data, rd_strobe} = '0;
  // Data is inverted after release so a stale word never looks current
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    {cmd_code, wr_strobe, rd_strobe, wr_data} <= {cmd, wr, !wr, d};
    @(posedge clk);
    {wr_strobe, rd_strobe, wr_data} <= {2'b00, ~d};
    // Answer stands for the cycle after the strobe edge; take it at the next edge
    @(posedge clk);
    q = rd_valid ? rd_data : 16'hdead;
  endtask
endmodule
`default_nettype wire

// ### sim/supply_fault_status_enable_tb_top.sv
// Self-checking bench for the fault status and enable registers
`timescale 1ns/10ps
`default_nettype none
module supply_fault_status_enable_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [13:0] flt = 14'h0000;
  logic [5:0] cfg = 6'h00;
  logic [7:0] cmd_code;
  logic wr_strobe, rd_strobe, rd_valid, chan0a_reservo_request, chan1a_reservo_request;
  logic [15:0] wr_data, rd_data, q;
  logic [13:0] latched_event_flags;
  int mismatches = 0, cmp_count = 0, cycles = 0, pulses = 0, p0;
  // Rows of mask and live faults; expected words follow from them
  logic [29:0] rows [3] = '{{16'h0000, 14'h3fff}, {16'h3fff, 14'h0001}, {16'heaaa, 14'h3e5a}};
  supply_fault_status_enable i_dut (.*, .chan0a_overvoltage_now(flt[0]), .chan0a_undervoltage_now(flt[1]),
    .chan0a_dac_limit_now(flt[2]), .chan0b_overvoltage_now(flt[3]), .chan0b_undervoltage_now(flt[4]),
    .chan1a_overvoltage_now(flt[5]), .chan1a_undervoltage_now(flt[6]), .chan1a_dac_limit_now(flt[7]),
    .chan1b_overvoltage_now(flt[8]), .chan1b_undervoltage_now(flt[9]), .supply_rail_over_now(flt[10]),
    .supply_rail_under_now(flt[11]), .twelve_volt_over_now(flt[12]), .twelve_volt_under_now(flt[13]),
    .chan0a_servo_enabled(cfg[0]), .chan0a_continuous_servo(cfg[1]), .chan0a_monitor_select(cfg[2]),
    .chan1a_servo_enabled(cfg[3]), .chan1a_continuous_servo(cfg[4]), .chan1a_monitor_select(cfg[5]));
  fault_host_model i_host (.*);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    pulses <= pulses + chan0a_reservo_request + chan1a_reservo_request;
    if (cycles == 3000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    i_host.access(1'b0, cmd, 16'h0000, q);
    chk(q, exp);
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h08, 16'h0000);
    foreach (rows[i])
    begin
      @(posedge clk) flt <= rows[i][13:0];
      i_host.access(1'b1, 8'h08, 16'h0000, q);
      i_host.access(1'b1, 8'h08, rows[i][29:14], q);
      repeat (4) @(posedge clk);
      rd(8'h00, {2'b00, rows[i][13:0]});
      rd(8'h11, {2'b00, rows[i][13:0] & rows[i][27:14]});
      rd(8'h08, rows[i][29:14]);
    end
    i_host.access(1'b1, 8'h00, 16'hffff, q);
    rd(8'h00, {2'b00, flt});
    rd(8'h55, 16'h0000);
    @(posedge clk) flt <= 14'h0000;
    repeat (4) @(posedge clk);
    rd(8'h00, 16'h0000);
    rd(8'h11, 16'h2a0a);
    rd(8'h11, 16'h0000);
    @(posedge clk) cfg <= 6'h2d;
    p0 = pulses;
    @(posedge clk) flt <= 14'h0021;
    repeat (8) @(posedge clk);
    chk(16'(pulses - p0), 16'h0002);
    @(posedge clk) {flt, cfg} <= {14'h0000, 6'h3f};
    repeat (4) @(posedge clk);
    p0 = pulses;
    @(posedge clk) flt <= 14'h0021;
    repeat (8) @(posedge clk);
    chk(16'(pulses - p0), 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
